//--- design/lgec_top.sv
// Functional notes
// - Off gap longer than 200 us makes the block emit a tickle pulse.
// - Tickle lasts 2 to 6 us; a following command merges with it.
// - Off gap and windowed on-time both decide; gaps of 200 us or less give no tickle.
// - Normally-off gate: beam only while gate driven high; low or open blocks.
// - Normally-on gate (reset default): an open gate counts as asserted.
// - Remote reset/start asserted keeps lasing disabled.
// - Reset release enters ready; keyswitch models wait five seconds first.
// - Lasing only with interlock asserted; keyswitch adds five-second delay.
// - On-time per 200 us window above tickle width suppresses the tickle.
// - Ready output high while enabled, low while disabled.
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`default_nettype none
`include "lgec_map.svh"
module lgec_top #(
  parameter int unsigned GAP_CYC = `LGEC_GAP_CYC,
  parameter int unsigned KEY_CYC = `LGEC_KEY_DELAY_CYC
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output var  logic [31:0]        hrdata,
  output var  logic               hreadyout,
  output var  logic               hresp,
  input  wire lgec_pkg::lgec_pins_s pins,
  output var  logic               beam_out,
  output var  logic               tickle_out,
  output var  logic               rf_drive,
  output var  logic               ready_out
);
  import lgec_pkg::*;

  localparam lgec_gap_t GAP_LIM = lgec_gap_t'(GAP_CYC);
  localparam lgec_tw_t  TW_MIN  = lgec_tw_t'(`LGEC_TICKLE_MIN_CYC);
  localparam lgec_tw_t  TW_MAX  = lgec_tw_t'(`LGEC_TICKLE_MAX_CYC);
  localparam lgec_tw_t  TW_DEF  = lgec_tw_t'(`LGEC_TICKLE_DEF_CYC);

  function automatic logic lgec_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Out-of-range widths are pulled into the legal tickle span
  function automatic lgec_tw_t lgec_clamp_tw(input logic [31:0] v);
    if (v < 32'(TW_MIN)) begin
      return TW_MIN;
    end else if (v > 32'(TW_MAX)) begin
      return TW_MAX;
    end
    return lgec_tw_t'(v);
  endfunction

  lgec_state_e state;
  lgec_state_e next_state;
  lgec_ctrl_s  ctrl;
  lgec_ctrl_s  next_ctrl;
  lgec_ap_s    ap;
  lgec_ap_s    next_ap;
  lgec_tw_t    tw;
  lgec_tw_t    next_tw;
  lgec_tw_t    tick;
  lgec_tw_t    next_tick;
  lgec_tw_t    tlen;
  lgec_tw_t    next_tlen;
  lgec_gap_t   gap;
  lgec_gap_t   next_gap;
  lgec_gap_t   win;
  lgec_gap_t   next_win;
  lgec_gap_t   acc;
  lgec_gap_t   next_acc;
  lgec_gap_t   on_last;
  lgec_gap_t   next_on_last;
  logic [31:0] next_hrdata;
  logic [31:0] rd_val;
  logic        next_beam;
  logic        next_tickle;
  logic        next_rf;
  logic        next_ready;
  logic        permit_in;
  logic        gate_ok;
  logic        gap_exp;
  logic        fire;
  logic        dly_done;

  assign permit_in = pins.interlock && !pins.reset_start;
  // Open gate reads as asserted only in the normally-on setting
  assign gate_ok = ctrl.norm_on ? (pins.gate_open || pins.gate)
                                : (!pins.gate_open && pins.gate);

  // Held in restart while disabled, so the count always starts on release
  lgec_delay #(.CYCLES(KEY_CYC)) u_key_delay (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .restart (state == LGEC_ST_HOLD),
    .done    (dly_done)
  );

  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr[7:0])
      `LGEC_OFS_CTRL:   rd_val = 32'(ctrl);
      `LGEC_OFS_TICKLE: rd_val = 32'(tw);
      `LGEC_OFS_STATUS: rd_val = {21'h00_0000, 3'(state), 1'b0, dly_done,
                                  pins.reset_start, pins.interlock, gate_ok,
                                  tickle_out, beam_out, ready_out};
      `LGEC_OFS_ONTIME: rd_val = 32'(on_last);
      default:          rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_ap     = ap;
    next_hrdata = hrdata;
    next_ctrl   = ctrl;
    next_tw     = tw;
    if (ce) begin
      if (hready) begin
        next_ap.valid = hsel && htrans[1];
        next_ap.write = hwrite;
        next_ap.word  = (hsize == `LGEC_HSIZE_WORD);
        next_ap.addr  = haddr[7:0];
        if (hsel && htrans[1] && !hwrite) begin
          next_hrdata = rd_val;
        end
      end
      if (ap.valid && ap.write && ap.word) begin
        if (lgec_hit(ap.addr, `LGEC_OFS_CTRL)) begin
          next_ctrl.norm_on = hwdata[`LGEC_CTRL_NORM_ON];
          next_ctrl.keysw   = hwdata[`LGEC_CTRL_KEYSW];
        end
        if (lgec_hit(ap.addr, `LGEC_OFS_TICKLE)) begin
          next_tw = lgec_clamp_tw(hwdata);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap        <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ctrl      <= `LGEC_CTRL_RESET;
      tw        <= TW_DEF;
    end else begin
      ap        <= next_ap;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ctrl      <= next_ctrl;
      tw        <= next_tw;
    end
  end

  always_comb begin
    next_state   = state;
    next_gap     = gap;
    next_win     = win;
    next_acc     = acc;
    next_on_last = on_last;
    next_tick    = tick;
    next_tlen    = tlen;
    next_beam    = beam_out;
    next_tickle  = tickle_out;
    next_rf      = rf_drive;
    next_ready   = ready_out;
    gap_exp      = 1'b0;
    fire         = 1'b0;
    if (ce) begin
      case (state)
        LGEC_ST_HOLD: begin
          if (permit_in) begin
            next_state = LGEC_ST_WAIT;
          end
        end
        LGEC_ST_WAIT: begin
          if (!permit_in) begin
            next_state = LGEC_ST_HOLD;
          end else if (!ctrl.keysw || dly_done) begin
            next_state = LGEC_ST_ARMED;
          end
        end
        LGEC_ST_ARMED: begin
          if (!permit_in) begin
            next_state = LGEC_ST_HOLD;
          end
        end
        default: next_state = LGEC_ST_HOLD;
      endcase
      // Counter restarts after each expiry, so a long silence ticks every gap period
      gap_exp  = !pins.cmd && (gap == GAP_LIM);
      fire     = gap_exp && (on_last <= lgec_gap_t'(tw));
      next_gap = (pins.cmd || gap_exp) ? '0 : gap + 1'b1;
      if (fire) begin
        next_tick = tw;
      end else if (tick != '0) begin
        next_tick = tick - 1'b1;
      end
      next_beam   = (state == LGEC_ST_ARMED) && permit_in && gate_ok && pins.cmd;
      next_tickle = (next_tick != '0);
      next_tlen   = tickle_out ? tlen + 1'b1 : '0;
      // Tickle and command share the drive, so a close command merges with it
      next_rf     = next_beam || next_tickle;
      if (win == GAP_LIM - 1'b1) begin
        next_win     = '0;
        next_on_last = acc + rf_drive;
        next_acc     = '0;
      end else begin
        next_win = win + 1'b1;
        next_acc = acc + rf_drive;
      end
      next_ready = (next_state == LGEC_ST_ARMED);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= LGEC_ST_HOLD;
      gap        <= '0;
      win        <= '0;
      acc        <= '0;
      on_last    <= '0;
      tick       <= '0;
      tlen       <= '0;
      beam_out   <= 1'b0;
      tickle_out <= 1'b0;
      rf_drive   <= 1'b0;
      ready_out  <= 1'b0;
    end else begin
      state      <= next_state;
      gap        <= next_gap;
      win        <= next_win;
      acc        <= next_acc;
      on_last    <= next_on_last;
      tick       <= next_tick;
      tlen       <= next_tlen;
      beam_out   <= next_beam;
      tickle_out <= next_tickle;
      rf_drive   <= next_rf;
      ready_out  <= next_ready;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_gap_fire;
    ce && !pins.cmd && (gap == GAP_LIM) && (on_last <= lgec_gap_t'(tw));
  endsequence
  sequence s_gap_quiet;
    ce && !pins.cmd && (gap < GAP_LIM) && (tick == '0);
  endsequence
  sequence s_ready_path;
    ce && (state == LGEC_ST_ARMED) && permit_in;
  endsequence

  AST_TICKLE_AFTER_GAP: assert property (s_gap_fire |=> tickle_out && tick == $past(tw))
    else $error("tickle missing after long gap");
  AST_NO_TICKLE_SHORT_GAP: assert property (s_gap_quiet |=> !tickle_out)
    else $error("tickle fired on short gap");
  AST_TICKLE_WIDTH: assert property (ce && tickle_out && !next_tickle |->
      (tlen + 1'b1 >= TW_MIN) && (tlen + 1'b1 <= TW_MAX))
    else $error("tickle width out of range");
  AST_ONTIME_SUPPRESS: assert property (ce && gap_exp && (on_last > lgec_gap_t'(tw))
      && (tick == '0) |=> !tickle_out)
    else $error("tickle not suppressed by on-time");
  AST_NORM_OFF_GATE: assert property (ce && !ctrl.norm_on &&
      (pins.gate_open || !pins.gate) |=> !beam_out)
    else $error("beam on with normally-off gate not driven high");
  AST_NORM_ON_OPEN: assert property (s_ready_path ##0 (ctrl.norm_on && pins.gate_open
      && pins.cmd) |=> beam_out)
    else $error("open gate did not enable beam in normally-on mode");
  AST_RESET_BLOCKS: assert property (ce && pins.reset_start |=> !beam_out && !ready_out)
    else $error("lasing while reset/start asserted");
  AST_INTERLOCK: assert property (ce && !pins.interlock |=> !beam_out && !ready_out)
    else $error("lasing without interlock");
  AST_KEY_DELAY: assert property ($rose(state == LGEC_ST_ARMED) && $past(ctrl.keysw)
      |-> $past(dly_done))
    else $error("armed before keyswitch delay");
  AST_READY_TRACKS: assert property (ce |=> ready_out == (state == LGEC_ST_ARMED))
    else $error("ready does not match enable state");
  AST_BEAM_CAUSE: assert property (ce && $past(ce) && beam_out |-> $past(pins.cmd) &&
      $past(state) == LGEC_ST_ARMED)
    else $error("beam without command or enable");
endmodule
`default_nettype wire

//--- design/lgec_map.svh
`ifndef LGEC_MAP_SVH
`define LGEC_MAP_SVH
`define LGEC_CLK_HZ          50_000_000
`define LGEC_CLK_PERIOD_NS   20
`define LGEC_GAP_US          200
`define LGEC_GAP_CYC         (`LGEC_GAP_US * (`LGEC_CLK_HZ / 1_000_000))
`define LGEC_TICKLE_MIN_NS   2000
`define LGEC_TICKLE_MAX_NS   6000
`define LGEC_TICKLE_DEF_NS   4000
`define LGEC_TICKLE_MIN_CYC  ((`LGEC_TICKLE_MIN_NS + `LGEC_CLK_PERIOD_NS - 1) / `LGEC_CLK_PERIOD_NS)
`define LGEC_TICKLE_MAX_CYC  (`LGEC_TICKLE_MAX_NS / `LGEC_CLK_PERIOD_NS)
`define LGEC_TICKLE_DEF_CYC  (`LGEC_TICKLE_DEF_NS / `LGEC_CLK_PERIOD_NS)
`define LGEC_KEY_DELAY_S     5
`define LGEC_KEY_DELAY_CYC   (`LGEC_KEY_DELAY_S * `LGEC_CLK_HZ)
`define LGEC_GAP_W           14
`define LGEC_KEY_W           28
`define LGEC_TW_W            9
`define LGEC_OFS_CTRL        8'h00
`define LGEC_OFS_TICKLE      8'h04
`define LGEC_OFS_STATUS      8'h08
`define LGEC_OFS_ONTIME      8'h0C
`define LGEC_CTRL_NORM_ON    0
`define LGEC_CTRL_KEYSW      1
`define LGEC_CTRL_RESET      2'h3
`define LGEC_HSIZE_WORD      3'h2
`define LGEC_ST_STATE_LSB    8
`endif

//--- design/lgec_pkg.sv
`default_nettype none
`include "lgec_map.svh"
package lgec_pkg;
  typedef logic [`LGEC_GAP_W-1:0] lgec_gap_t;
  typedef logic [`LGEC_KEY_W-1:0] lgec_key_t;
  typedef logic [`LGEC_TW_W-1:0]  lgec_tw_t;
  typedef enum logic [2:0] {
    LGEC_ST_HOLD  = 3'b001,
    LGEC_ST_WAIT  = 3'b010,
    LGEC_ST_ARMED = 3'b100
  } lgec_state_e;
  typedef struct packed {
    logic cmd;
    logic gate;
    logic gate_open;
    logic interlock;
    logic reset_start;
  } lgec_pins_s;
  typedef struct packed {
    logic keysw;
    logic norm_on;
  } lgec_ctrl_s;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       word;
    logic [7:0] addr;
  } lgec_ap_s;
endpackage
`default_nettype wire

//--- design/lgec_delay.sv
`default_nettype none
`include "lgec_map.svh"
module lgec_delay #(
  parameter int unsigned CYCLES = `LGEC_KEY_DELAY_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic restart,
  output var  logic done
);
  import lgec_pkg::*;
  localparam lgec_key_t LIM = lgec_key_t'(CYCLES - 1);
  lgec_key_t cnt;
  lgec_key_t next_cnt;
  logic      next_done;

  always_comb begin
    next_cnt  = cnt;
    next_done = done;
    if (ce) begin
      if (restart) begin
        next_cnt  = LIM;
        next_done = 1'b0;
      end else if (!done) begin
        if (cnt == '0) begin
          next_done = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= '0;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end
endmodule
`default_nettype wire

//--- verif/lgec_ctrl_model.sv
`default_nettype none
module lgec_ctrl_model
  import lgec_pkg::*;
#(
  parameter int unsigned GATE_HOLD = 25000
) (
  input  wire logic                 hclk,
  output var  lgec_pkg::lgec_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Starts disconnected gate, no interlock, reset/start held
  initial pins = 5'h05;

  // A system with no interlock just keeps il at 1
  task automatic lines(input logic g, input logic go, input logic il, input logic rs);
    @(posedge hclk);
    if (g !== pins.gate)
      repeat (GATE_HOLD) @(posedge hclk);
    pins.gate        <= g;
    pins.gate_open   <= go;
    pins.interlock   <= il;
    pins.reset_start <= rs;
  endtask

  task automatic level(input logic v);
    @(posedge hclk);
    pins.cmd <= v;
  endtask

  // Duty is trimmed, never raised, so callers cannot overheat the tube
  task automatic pwm(input int on, input int off, input int reps);
    int hi;
    hi = on;
    while (hi * 100 > (on + off) * 95)
      hi--;
    repeat (reps) begin
      level(1'h1);
      repeat (hi - 1) @(posedge hclk);
      level(1'h0);
      repeat (on + off - hi - 1) @(posedge hclk);
    end
  endtask
endmodule
`default_nettype wire

//--- verif/laser_gate_enable_control_tb.sv
`default_nettype none
module laser_gate_enable_control_tb;
  import lgec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned GAP = 400;
  localparam int unsigned KEY = 20;

  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic        beam_out;
  logic        tickle_out;
  logic        rf_drive;
  logic        ready_out;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  lgec_pins_s  pins;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;

  lgec_top #(.GAP_CYC(GAP), .KEY_CYC(KEY)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pins(pins), .beam_out(beam_out), .tickle_out(tickle_out),
    .rf_drive(rf_drive), .ready_out(ready_out)
  );

  // Gate spacing scaled down from 1 kHz to keep the run short
  lgec_ctrl_model #(.GATE_HOLD(100)) u_ctrl (.hclk(hclk), .pins(pins));

  initial begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end

  task automatic end_sim;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [2:0] sz);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= sz;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel   <= 1'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    chk1("hresp", 1'h0, hresp);
    chk1("hreadyout", 1'h1, hreadyout);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0000_0000, 3'h2);
    chk(nm, e, rd);
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask

  task automatic wait_tickle;
    n = 0;
    while (tickle_out !== 1'h1 && n < 1500) begin
      settle(1);
      n++;
    end
  endtask

  initial begin
    hresetn = 1'h0;
    ce      = 1'h1;
    hsel    = 1'h0;
    haddr   = 32'h0000_0000;
    htrans  = 2'h0;
    hwrite  = 1'h0;
    hsize   = 3'h2;
    hwdata  = 32'h0000_0000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    rd_chk("ctrl", 8'h00, 32'h0000_0003);
    rd_chk("tickle", 8'h04, 32'h0000_00C8);
    rd_chk("status_reset", 8'h08, 32'h0000_0128);
    xfer(1'h1, 8'h10, 32'h0000_FFFF, 3'h2);
    rd_chk("unmapped", 8'h10, 32'h0000_0000);
    xfer(1'h1, 8'h04, 32'h0000_01F4, 3'h2);
    rd_chk("clamp_hi", 8'h04, 32'h0000_012C);
    xfer(1'h1, 8'h04, 32'h0000_0032, 3'h2);
    rd_chk("clamp_lo", 8'h04, 32'h0000_0064);
    xfer(1'h1, 8'h04, 32'h0000_00FA, 3'h0);
    rd_chk("byte_write", 8'h04, 32'h0000_0064);
    ce <= 1'h0;
    xfer(1'h1, 8'h04, 32'h0000_00FA, 3'h2);
    ce <= 1'h1;
    rd_chk("ce_frozen", 8'h04, 32'h0000_0064);
    u_ctrl.lines(1'h0, 1'h1, 1'h1, 1'h0);
    settle(10);
    chk1("ready_key", 1'h0, ready_out);
    settle(30);
    chk1("ready_on", 1'h1, ready_out);
    u_ctrl.level(1'h1);
    settle(4);
    chk1("beam_open_norm_on", 1'h1, beam_out);
    xfer(1'h1, 8'h00, 32'h0000_0002, 3'h2);
    settle(4);
    chk1("beam_open_norm_off", 1'h0, beam_out);
    u_ctrl.lines(1'h1, 1'h0, 1'h1, 1'h0);
    settle(4);
    chk1("beam_gate_high", 1'h1, beam_out);
    u_ctrl.lines(1'h0, 1'h0, 1'h1, 1'h0);
    settle(4);
    chk1("beam_gate_low", 1'h0, beam_out);
    u_ctrl.lines(1'h1, 1'h0, 1'h1, 1'h1);
    settle(4);
    chk1("ready_reset", 1'h0, ready_out);
    chk1("beam_reset", 1'h0, beam_out);
    u_ctrl.lines(1'h1, 1'h0, 1'h1, 1'h0);
    settle(10);
    chk1("ready_restart_wait", 1'h0, ready_out);
    settle(30);
    chk1("ready_restart", 1'h1, ready_out);
    chk1("beam_restart", 1'h1, beam_out);
    u_ctrl.lines(1'h1, 1'h0, 1'h0, 1'h0);
    settle(4);
    chk1("beam_no_interlock", 1'h0, beam_out);
    xfer(1'h1, 8'h00, 32'h0000_0000, 3'h2);
    u_ctrl.lines(1'h1, 1'h0, 1'h1, 1'h0);
    settle(4);
    chk1("ready_no_key", 1'h1, ready_out);
    u_ctrl.level(1'h0);
    wait_tickle();
    chk1("gap_quiet", 1'h1, n >= GAP);
    chk1("tickle_fire", 1'h1, tickle_out);
    n = 0;
    while (tickle_out === 1'h1 && n < 400) begin
      settle(1);
      n++;
    end
    chk("tickle_width", 32'h0000_0064, n);
    wait_tickle();
    settle(20);
    u_ctrl.level(1'h1);
    n = 0;
    repeat (200) begin
      settle(1);
      if (rf_drive !== 1'h1)
        n++;
    end
    chk("merge_gaps", 32'h0000_0000, n);
    // Drive held on long enough that the last finished window is fully lit
    settle(600);
    rd_chk("ontime_full", 8'h0C, 32'h0000_0190);
    fork
      u_ctrl.pwm(20, 300, 5);
      begin
        n = 0;
        repeat (1600) begin
          settle(1);
          if (tickle_out === 1'h1)
            n++;
        end
      end
    join
    chk("short_gap_tickle", 32'h0000_0000, n);
    end_sim();
  end
endmodule
`default_nettype wire
